// [verilog/move_return_rotate_ops.sv]
/*
  Execution logic for register moves, immediate load, idle, returns and
  rotate-left-through-carry. Software issues one instruction at a time
  over classic Wishbone. Assumes file register and stack read data come
  combinationally from logic on the same clock.
*/
`timescale 1ns/100ps
`include "exec_defines.svh"

module move_return_rotate_ops (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire exec_pkg::byte_t file_rdata_i,
  output logic [6:0] file_addr_o,
  output exec_pkg::byte_t file_wdata_o,
  output logic file_we_o,
  input wire exec_pkg::pc_t stack_rdata_i,
  output logic [2:0] stack_level_o,
  output exec_pkg::pc_t pc_o,
  output exec_pkg::byte_t accumulator_o,
  output logic zero_o,
  output logic carry_o,
  output logic global_irq_enable_o,
  output logic busy_o
);
  import exec_pkg::*;

  state_t state;
  op_t op_q;
  logic dest_q;
  byte_t imm_q;
  logic [31:0] instr_word;
  logic bus_req, bus_wr, in_exec, is_return, idle_write;
  byte_t rot_result;

  // bus request is taken once, in the cycle before ack
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  // register writes other than issue are refused while executing
  assign idle_write = bus_wr & (state == st_idle) & wb_sel_i[0];
  assign in_exec = (state == st_exec);
  assign is_return = (op_q == op_interrupt_return_enable) | (op_q == op_return_with_immediate);
  assign rot_result = {file_rdata_i[6:0], carry_o};

  // wishbone answer: one registered ack, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i) begin
        case (wb_adr_i)
          `ADDR_INSTR: wb_dat_o <= instr_word;
          `ADDR_ACC: wb_dat_o <= {24'h00_0000, accumulator_o};
          `ADDR_STATUS: wb_dat_o <= {28'h000_0000, busy_o, global_irq_enable_o, carry_o, zero_o};
          `ADDR_PC: wb_dat_o <= {21'h00_0000, pc_o};
          `ADDR_SP: wb_dat_o <= {29'h0000_0000, stack_level_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // issue and sequencing; returns take a second settle cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_idle;
      op_q <= op_idle_instruction;
      dest_q <= 1'b0;
      imm_q <= 8'h00;
      instr_word <= 32'h0000_0000;
      busy_o <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (bus_wr & (wb_adr_i == `ADDR_INSTR) & (&wb_sel_i[2:0])) begin
            instr_word <= {13'h0000, wb_dat_i[18:0]};
            op_q <= op_t'(wb_dat_i[`OP_MSB:`OP_LSB]);
            dest_q <= wb_dat_i[`DEST_BIT];
            imm_q <= wb_dat_i[`IMM_MSB:`IMM_LSB];
            state <= st_exec;
            busy_o <= 1'b1;
          end
        end
        st_exec: begin
          if (is_return) begin
            state <= st_settle;
          end else begin
            state <= st_idle;
            busy_o <= 1'b0;
          end
        end
        st_settle: begin
          state <= st_idle;
          busy_o <= 1'b0;
        end
        default: begin
          state <= st_idle;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // accumulator and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulator_o <= `ACC_RST;
      zero_o <= 1'b0;
      carry_o <= 1'b0;
      global_irq_enable_o <= 1'b0;
    end else if (in_exec) begin
      case (op_q)
        op_immediate_to_acc_load: accumulator_o <= imm_q;
        op_return_with_immediate: accumulator_o <= imm_q;
        op_file_register_move: begin
          if (!dest_q) begin
            accumulator_o <= file_rdata_i;
          end
          zero_o <= (file_rdata_i == 8'h00);
        end
        op_interrupt_return_enable: global_irq_enable_o <= 1'b1;
        op_rotate_left_carry: begin
          if (!dest_q) begin
            accumulator_o <= rot_result;
          end
          carry_o <= file_rdata_i[7];
        end
        default: begin
          // accumulator-to-file moves and idle leave accumulator and flags alone
        end
      endcase
    end else if (idle_write & (wb_adr_i == `ADDR_ACC)) begin
      accumulator_o <= wb_dat_i[7:0];
    end else if (idle_write & (wb_adr_i == `ADDR_STATUS)) begin
      zero_o <= wb_dat_i[`STAT_ZERO];
      carry_o <= wb_dat_i[`STAT_CARRY];
      global_irq_enable_o <= wb_dat_i[`STAT_GIE];
    end
  end

  // program counter and stack level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= `PC_RST;
      stack_level_o <= `SP_RST;
    end else if (in_exec) begin
      if (is_return) begin
        pc_o <= stack_rdata_i;
        if (stack_level_o != 3'h0) begin
          stack_level_o <= stack_level_o - 3'h1;
        end
      end else begin
        pc_o <= pc_o + 11'h001;
      end
    end else if (idle_write & (wb_adr_i == `ADDR_PC) & wb_sel_i[1]) begin
      pc_o <= wb_dat_i[10:0];
    end else if (idle_write & (wb_adr_i == `ADDR_SP)) begin
      stack_level_o <= wb_dat_i[2:0];
    end
  end

  // file register bus: address set at issue, write strobe one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_addr_o <= `FADDR_RST;
      file_wdata_o <= 8'h00;
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= 1'b0;
      if ((state == st_idle) & bus_wr & (wb_adr_i == `ADDR_INSTR) & (&wb_sel_i[2:0])) begin
        file_addr_o <= wb_dat_i[`FADDR_MSB:`FADDR_LSB];
      end
      if (in_exec) begin
        case (op_q)
          op_acc_to_file_move: begin
            file_wdata_o <= accumulator_o;
            file_we_o <= 1'b1;
          end
          op_file_register_move: begin
            file_wdata_o <= file_rdata_i;
            file_we_o <= dest_q;
          end
          op_rotate_left_carry: begin
            file_wdata_o <= rot_result;
            file_we_o <= dest_q;
          end
          default: file_we_o <= 1'b0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pop_done;
    (state == st_settle) ##1 (state == st_idle);
  endsequence

  property p_acc_to_file;
    in_exec && op_q == op_acc_to_file_move |=>
      file_we_o && file_wdata_o == $past(accumulator_o) && $stable(accumulator_o) && $stable(carry_o)
      && $stable(zero_o) && state == st_idle;
  endproperty
  a_acc_to_file: assert property (p_acc_to_file) else $error("acc to file move wrong");

  property p_imm_load;
    in_exec && op_q == op_immediate_to_acc_load |=> accumulator_o == $past(imm_q) && $stable(zero_o) && $stable(carry_o);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("immediate load wrong");

  property p_idle_instr;
    in_exec && op_q == op_idle_instruction |=>
      pc_o == $past(pc_o) + 11'h001 && $stable(accumulator_o) && !file_we_o && state == st_idle;
  endproperty
  a_idle_instr: assert property (p_idle_instr) else $error("idle instruction changed state");

  property p_move_dest;
    in_exec && op_q == op_file_register_move |=>
      (dest_q ? (file_we_o && file_wdata_o == $past(file_rdata_i)) : (!file_we_o && accumulator_o == $past(file_rdata_i)));
  endproperty
  a_move_dest: assert property (p_move_dest) else $error("file move routed wrong");

  property p_move_zero;
    in_exec && op_q == op_file_register_move |=> zero_o == ($past(file_rdata_i) == 8'h00);
  endproperty
  a_move_zero: assert property (p_move_zero) else $error("zero flag wrong after move");

  property p_int_return;
    in_exec && op_q == op_interrupt_return_enable |=>
      global_irq_enable_o && pc_o == $past(stack_rdata_i) && $stable(zero_o) ##0 s_pop_done;
  endproperty
  a_int_return: assert property (p_int_return) else $error("interrupt return wrong");

  property p_pop_level;
    in_exec && is_return && stack_level_o != 3'h0 |=> stack_level_o == $past(stack_level_o) - 3'h1;
  endproperty
  a_pop_level: assert property (p_pop_level) else $error("stack level not decremented");

  property p_ret_imm;
    in_exec && op_q == op_return_with_immediate |=>
      accumulator_o == $past(imm_q) && pc_o == $past(stack_rdata_i) && $stable(carry_o) ##0 s_pop_done;
  endproperty
  a_ret_imm: assert property (p_ret_imm) else $error("return with immediate wrong");

  property p_rotate;
    in_exec && op_q == op_rotate_left_carry |=>
      carry_o == $past(file_rdata_i[7]) && file_wdata_o == {$past(file_rdata_i[6:0]), $past(carry_o)};
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result wrong");

  property p_rotate_dest;
    in_exec && op_q == op_rotate_left_carry && !dest_q |=>
      !file_we_o && accumulator_o == file_wdata_o && $stable(zero_o) && state == st_idle;
  endproperty
  a_rotate_dest: assert property (p_rotate_dest) else $error("rotate destination wrong");

endmodule : move_return_rotate_ops

// [inc/exec_defines.svh]
/*
  Offsets, field positions and reset values for the move/return/rotate
  execution block. Assumes a 32-bit classic Wishbone register bus.
*/
// Summary of operation
// - accumulator written to addressed file register, flags kept
// - immediate byte loads accumulator, flags kept
// - idle instruction only advances program counter
// - file value goes to accumulator or back
// - file move sets zero flag from value
// - interrupt return pops pc, sets interrupt enable
// - every return pops stack, pointer decrements once unless already zero
// - return with immediate loads accumulator and pops
// - rotate left through carry, bit seven to carry
// - rotate result to accumulator or register, carry only
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// register byte addresses
`define ADDR_INSTR 8'h00
`define ADDR_ACC 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_PC 8'h0C
`define ADDR_SP 8'h10

// instruction register fields
`define OP_LSB 0
`define OP_MSB 2
`define DEST_BIT 3
`define FADDR_LSB 4
`define FADDR_MSB 10
`define IMM_LSB 11
`define IMM_MSB 18

// status register bits
`define STAT_ZERO 0
`define STAT_CARRY 1
`define STAT_GIE 2
`define STAT_BUSY 3

// reset values
`define ACC_RST 8'h00
`define PC_RST 11'h000
`define SP_RST 3'h0
`define FADDR_RST 7'h00

`endif

// [inc/exec_pkg.sv]
/*
  Types for the move/return/rotate execution block.
  Assumes exec_defines.svh supplies the numeric constants.
*/
package exec_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [10:0] pc_t;

  // instruction classes carried in the instruction register
  typedef enum logic [2:0] {
    op_idle_instruction = 3'h0,
    op_acc_to_file_move = 3'h1,
    op_immediate_to_acc_load = 3'h2,
    op_file_register_move = 3'h3,
    op_interrupt_return_enable = 3'h4,
    op_return_with_immediate = 3'h5,
    op_rotate_left_carry = 3'h6
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_settle = 2'b10
  } state_t;
endpackage : exec_pkg

// [verif/tb_move_return_rotate_ops.sv]
/*
  Bench for the move/return/rotate block: Wishbone tasks issue instructions,
  then checks of accumulator, flags, pc and stack level against expectations.
  Assumes the file register and stack answer combinationally at the ports.
*/
`timescale 1ns/100ps
`include "exec_defines.svh"

module tb_move_return_rotate_ops;
  import exec_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [6:0] file_addr_o;
  byte_t file_wdata_o;
  logic file_we_o;
  logic [2:0] stack_level_o;
  pc_t pc_o;
  byte_t accumulator_o;
  logic zero_o, carry_o, global_irq_enable_o, busy_o;
  byte_t fmem [128];
  pc_t stk [8];
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // file register and stack stand-ins, answered combinationally
  always @(posedge clk_i) if (file_we_o) fmem[file_addr_o] <= file_wdata_o;

  move_return_rotate_ops DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .file_rdata_i(fmem[file_addr_o]), .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .stack_rdata_i(stk[stack_level_o]),
    .stack_level_o(stack_level_o), .pc_o(pc_o), .accumulator_o(accumulator_o), .zero_o(zero_o),
    .carry_o(carry_o), .global_irq_enable_o(global_irq_enable_o), .busy_o(busy_o));

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // hang guard, far beyond the roughly sixty cycles of the sequence
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // classic single cycle; request held until ack is sampled
  task wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  // issue one instruction, wait for busy to clear, then one edge more:
  // the file stand-in only takes a write-back at the edge after the strobe
  task exec(input logic [2:0] op, input logic d, input logic [6:0] fa, input byte_t imm);
    int i;
    wb(1'b1, `ADDR_INSTR, 4'hF, {13'h0, imm, fa, d, op});
    for (i = 0; i < 8; i++) begin
      #1;
      if (busy_o === 1'b0) break;
      @(posedge clk_i);
    end
    check("extra cycles", i, ((op == op_interrupt_return_enable) || (op == op_return_with_immediate)) ? 32'h1 : 32'h0);
    @(posedge clk_i);
    #1;
  endtask : exec

  // flags packed as gie, carry, zero
  task state(input byte_t acc, input logic [2:0] fl, input pc_t pc);
    check("acc", accumulator_o, acc);
    check("flags", {global_irq_enable_o, carry_o, zero_o}, fl);
    check("pc", pc_o, pc);
  endtask : state

  initial begin
    foreach (fmem[i]) fmem[i] = 8'h00;
    fmem[5] = 8'hA5;
    foreach (stk[i]) stk[i] = 11'h000;
    stk[2] = 11'h123;
    stk[1] = 11'h0AB;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `ADDR_ACC, 4'hF, 32'h0);
    check("acc reset", rd, 32'h0);
    wb(1'b0, 8'h14, 4'hF, 32'h0);
    check("unmapped", rd, 32'h0);
    exec(op_immediate_to_acc_load, 1'b0, 7'h00, 8'h55);
    state(8'h55, 3'h0, 11'h001);
    exec(op_acc_to_file_move, 1'b0, 7'h7F, 8'h00);
    state(8'h55, 3'h0, 11'h002);
    check("file 127", fmem[127], 32'h55);
    check("file addr", file_addr_o, 32'h7F);
    check("file data", file_wdata_o, 32'h55);
    exec(op_idle_instruction, 1'b0, 7'h00, 8'h00);
    state(8'h55, 3'h0, 11'h003);
    exec(op_file_register_move, 1'b0, 7'h03, 8'h00);
    state(8'h00, 3'h1, 11'h004);
    exec(op_file_register_move, 1'b1, 7'h7F, 8'h00);
    state(8'h00, 3'h0, 11'h005);
    check("file 127 back", fmem[127], 32'h55);
    exec(op_rotate_left_carry, 1'b1, 7'h05, 8'h00);
    state(8'h00, 3'h2, 11'h006);
    check("rot to file", fmem[5], 32'h4A);
    exec(op_rotate_left_carry, 1'b0, 7'h05, 8'h00);
    state(8'h95, 3'h0, 11'h007);
    check("rot src kept", fmem[5], 32'h4A);
    wb(1'b1, `ADDR_SP, 4'h1, 32'h2);
    exec(op_interrupt_return_enable, 1'b0, 7'h00, 8'h00);
    state(8'h95, 3'h4, 11'h123);
    check("level", stack_level_o, 32'h1);
    exec(op_return_with_immediate, 1'b0, 7'h00, 8'h77);
    state(8'h77, 3'h4, 11'h0AB);
    check("level", stack_level_o, 32'h0);
    wb(1'b0, `ADDR_STATUS, 4'hF, 32'h0);
    check("status", rd, 32'h4);
    wb(1'b0, `ADDR_PC, 4'hF, 32'h0);
    check("pc read", rd, 32'h0AB);
    // mid-run reset: every output but wb_dat_o must fall back to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    state(8'h00, 3'h0, 11'h000);
    check("level reset", stack_level_o, 32'h0);
    check("busy reset", busy_o, 32'h0);
    check("we reset", file_we_o, 32'h0);
    check("addr reset", file_addr_o, 32'h0);
    check("wdata reset", file_wdata_o, 32'h0);
    check("ack reset", wb_ack_o, 32'h0);
    wb(1'b0, `ADDR_PC, 4'hF, 32'h0);
    check("pc after reset", rd, 32'h0);
    summarize();
  end
endmodule : tb_move_return_rotate_ops
